// *** core/nvid_pkg.sv ***
package nvid_pkg;

	////////////////////////////////////////////////////////////////////////
	// Bus widths
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	localparam int WORD_W = 16;

	////////////////////////////////////////////////////////////////////////
	// Byte image: three threshold words, then four laser frequency words
	localparam int NUM_WORDS = 7;
	localparam int NUM_BYTES = 14;
	localparam int IDX_W     = 4;
	localparam int PAGE_TWO_BYTES = 6;
	localparam int NUM_THR   = 3;

	localparam logic [2:0] WI_RXP_HIGH_WARN_MAX = 3'h0;
	localparam logic [2:0] WI_RXP_LOW_WARN_MAX  = 3'h1;
	localparam logic [2:0] WI_RXP_LOW_ALARM_MAX = 3'h2;
	localparam logic [2:0] WI_MIN_FREQ_COARSE   = 3'h3;
	localparam logic [2:0] WI_MIN_FREQ_FINE     = 3'h4;
	localparam logic [2:0] WI_MAX_FREQ_COARSE   = 3'h5;
	localparam logic [2:0] WI_MAX_FREQ_FINE     = 3'h6;

	////////////////////////////////////////////////////////////////////////
	// Byte addresses
	localparam logic [ADDR_W-1:0] RX_POWER_HIGH_WARNING_PERMITTED_MAX = 16'h80f2;
	localparam logic [ADDR_W-1:0] RX_POWER_LOW_WARNING_PERMITTED_MAX  = 16'h80f4;
	localparam logic [ADDR_W-1:0] RX_POWER_LOW_ALARM_PERMITTED_MAX    = 16'h80f6;
	localparam logic [ADDR_W-1:0] PAGE_TWO_RESERVED_TAIL_LO           = 16'h80f8;
	localparam logic [ADDR_W-1:0] PAGE_TWO_RESERVED_TAIL_HI           = 16'h80fe;
	localparam logic [ADDR_W-1:0] PAGE_TWO_CHECKSUM                   = 16'h80ff;
	localparam logic [ADDR_W-1:0] PAGE_THREE_CHECKSUM_SLOT            = 16'h8180;
	localparam logic [ADDR_W-1:0] TX_MIN_LASER_FREQ_COARSE            = 16'h818a;
	localparam logic [ADDR_W-1:0] TX_MIN_LASER_FREQ_FINE              = 16'h818c;
	localparam logic [ADDR_W-1:0] TX_MAX_LASER_FREQ_COARSE            = 16'h818e;
	localparam logic [ADDR_W-1:0] TX_MAX_LASER_FREQ_FINE              = 16'h8190;
	localparam logic [ADDR_W-1:0] SEG_B_LAST                          = 16'h8191;

	localparam logic [IDX_W-1:0] SEG_B_FIRST_IDX = 4'h6;

	////////////////////////////////////////////////////////////////////////
	// Values
	localparam logic [WORD_W-1:0] FINE_STEP_MAX   = 16'h4e1f;
	localparam logic [WORD_W-1:0] THR_UNSUPPORTED = 16'h0000;
	localparam logic [DATA_W-1:0] BYTE_ZERO       = 8'h00;

endpackage : nvid_pkg

// *** core/nvid_regs.sv ***
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module nvid_regs
	import nvid_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              resetn,
	input  wire logic              clk_en,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	input  wire logic              nv_load,
	input  wire logic [IDX_W-1:0]  nv_index,
	input  wire logic [DATA_W-1:0] nv_data,
	input  wire logic [DATA_W-1:0] page_two_head_sum,
	output logic      [NUM_THR-1:0] thr_supported,
	output logic                   fine_range_err
);

	////////////////////////////////////////////////////////////////////////////
	// State

	typedef struct packed {
		logic [NUM_BYTES-1:0][DATA_W-1:0] image;
		logic [DATA_W-1:0]                rdata;
		logic                             range_err;
	} nvid_state_t;

	nvid_state_t st_q;
	nvid_state_t st_d;
	logic        rst_meta_q;
	logic        rst_n_q;

	////////////////////////////////////////////////////////////////////////////
	// Functions

	// Decode a byte address into an image index; hit is low outside storage
	function automatic logic [IDX_W:0] nvid_decode(input logic [ADDR_W-1:0] a);
		logic [ADDR_W-1:0] off;
		off = '0;
		if (a >= RX_POWER_HIGH_WARNING_PERMITTED_MAX && a < PAGE_TWO_RESERVED_TAIL_LO)
		begin
			off = a - RX_POWER_HIGH_WARNING_PERMITTED_MAX;
			return {1'b1, off[IDX_W-1:0]};
		end
		if (a >= TX_MIN_LASER_FREQ_COARSE && a <= SEG_B_LAST)
		begin
			off = a - TX_MIN_LASER_FREQ_COARSE;
			return {1'b1, off[IDX_W-1:0] + SEG_B_FIRST_IDX};
		end
		return '0;
	endfunction : nvid_decode

	// High byte sits at the even index, which is the lower address
	function automatic logic [WORD_W-1:0] nvid_word(
		input logic [NUM_BYTES-1:0][DATA_W-1:0] img,
		input logic [2:0]                       wi
	);
		logic [IDX_W-1:0] hi;
		hi = {wi, 1'b0};
		return {img[hi], img[hi + 4'h1]};
	endfunction : nvid_word

	function automatic logic [DATA_W-1:0] nvid_cksum(
		input logic [NUM_BYTES-1:0][DATA_W-1:0] img,
		input logic [DATA_W-1:0]                head
	);
		logic [DATA_W-1:0] s;
		s = head;
		// Reserved tail bytes are zero and add nothing
		for (int i = 0; i < PAGE_TWO_BYTES; i++)
		begin
			s = s + img[i];
		end
		return s;
	endfunction : nvid_cksum

	////////////////////////////////////////////////////////////////////////////
	// Reset release

	// Release is synchronised so every state flop leaves reset on one edge
	always_ff @(posedge mclk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_meta_q <= 1'b0;
			rst_n_q    <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_n_q    <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state

	logic [IDX_W:0]    rd_dec;
	logic [DATA_W-1:0] cksum;
	logic [WORD_W-1:0] min_fine;
	logic [WORD_W-1:0] max_fine;

	always_comb
	begin
		st_d     = st_q;
		rd_dec   = nvid_decode(reg_addr);
		cksum    = nvid_cksum(st_q.image, page_two_head_sum);
		min_fine = nvid_word(st_q.image, WI_MIN_FREQ_FINE);
		max_fine = nvid_word(st_q.image, WI_MAX_FREQ_FINE);

		// Only the nonvolatile loader fills the image; host writes fall away
		if (nv_load && nv_index < IDX_W'(NUM_BYTES))
		begin
			st_d.image[nv_index] = nv_data;
		end

		if (reg_rd)
		begin
			if (reg_addr == PAGE_TWO_CHECKSUM)
			begin
				st_d.rdata = cksum;
			end
			else if (rd_dec[IDX_W])
			begin
				st_d.rdata = st_q.image[rd_dec[IDX_W-1:0]];
			end
			else
			begin
				// Reserved and unmapped bytes read zero
				st_d.rdata = BYTE_ZERO;
			end
		end

		// Flags a badly provisioned image rather than clamping it
		st_d.range_err = (min_fine > FINE_STEP_MAX) || (max_fine > FINE_STEP_MAX);
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge mclk or negedge rst_n_q)
	begin
		if (!rst_n_q)
		begin
			st_q <= '0;
		end
		else if (clk_en)
		begin
			st_q <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign reg_rdata      = st_q.rdata;
	assign fine_range_err = st_q.range_err;

	always_comb
	begin
		for (int t = 0; t < NUM_THR; t++)
		begin
			thr_supported[t] = nvid_word(st_q.image, 3'(t)) != THR_UNSUPPORTED;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	logic [WORD_W-1:0] min_coarse;
	logic [WORD_W-1:0] max_coarse;
	logic signed [WORD_W-1:0] thr_hw;
	logic [IDX_W:0]    wr_dec;
	logic [WORD_W-1:0] thr_lw;
	logic [WORD_W-1:0] thr_la;

	assign min_coarse = nvid_word(st_q.image, WI_MIN_FREQ_COARSE);
	assign max_coarse = nvid_word(st_q.image, WI_MAX_FREQ_COARSE);
	assign thr_hw     = nvid_word(st_q.image, WI_RXP_HIGH_WARN_MAX);
	assign wr_dec     = nvid_decode(reg_addr);
	assign thr_lw     = nvid_word(st_q.image, WI_RXP_LOW_WARN_MAX);
	assign thr_la     = nvid_word(st_q.image, WI_RXP_LOW_ALARM_MAX);

	checksum_read_a: assert property (
		@(posedge mclk) disable iff (!rst_n_q)
		clk_en && reg_rd && reg_addr == PAGE_TWO_CHECKSUM
		|=> reg_rdata == $past(cksum))
	else $error("checksum byte mismatch");

	msb_low_addr_a: assert property (
		@(posedge mclk) disable iff (!rst_n_q)
		clk_en && reg_rd && reg_addr == TX_MAX_LASER_FREQ_FINE
		|=> reg_rdata == $past(max_fine[WORD_W-1:DATA_W]))
	else $error("high byte not at lower address");

	min_coarse_a: assert property (
		@(posedge mclk) disable iff (!rst_n_q)
		clk_en && reg_rd && reg_addr == TX_MIN_LASER_FREQ_COARSE + 16'h0001
		|=> reg_rdata == $past(min_coarse[DATA_W-1:0]))
	else $error("min coarse low byte wrong");

	fine_limit_a: assert property (
		@(posedge mclk) disable iff (!rst_n_q)
		clk_en && (min_fine > FINE_STEP_MAX) ##1 clk_en && $stable(st_q.image)
		|=> fine_range_err)
	else $error("fine step overflow not flagged");

	max_coarse_a: assert property (
		@(posedge mclk) disable iff (!rst_n_q)
		clk_en && reg_rd && reg_addr == TX_MAX_LASER_FREQ_COARSE
		|=> reg_rdata == $past(max_coarse[WORD_W-1:DATA_W]))
	else $error("max coarse high byte wrong");

	thr_word_a: assert property (
		@(posedge mclk) disable iff (!rst_n_q)
		clk_en && reg_rd && reg_addr == RX_POWER_HIGH_WARNING_PERMITTED_MAX
		|=> reg_rdata == $past(thr_hw[WORD_W-1:DATA_W]))
	else $error("threshold sign byte wrong");

	thr_unsupported_a: assert property (
		@(posedge mclk) disable iff (!rst_n_q)
		thr_supported[0] == (thr_hw != THR_UNSUPPORTED))
	else $error("support flag disagrees with word");

	reserved_zero_a: assert property (
		@(posedge mclk) disable iff (!rst_n_q)
		clk_en && reg_rd && ((reg_addr >= PAGE_TWO_RESERVED_TAIL_LO
		&& reg_addr <= PAGE_TWO_RESERVED_TAIL_HI) || reg_addr == PAGE_THREE_CHECKSUM_SLOT)
		|=> reg_rdata == BYTE_ZERO)
	else $error("reserved byte not zero");

	host_write_ignored_a: assert property (
		@(posedge mclk) disable iff (!rst_n_q)
		clk_en && reg_wr && !nv_load && wr_dec[IDX_W]
		|=> $stable(st_q.image))
	else $error("host write changed image");

	max_fine_flag_a: assert property (
		@(posedge mclk) disable iff (!rst_n_q)
		clk_en && (max_fine > FINE_STEP_MAX) ##1 clk_en && $stable(st_q.image)
		|=> fine_range_err)
	else $error("max fine step overflow not flagged");

	fine_clear_a: assert property (
		@(posedge mclk) disable iff (!rst_n_q)
		clk_en && (min_fine <= FINE_STEP_MAX) && (max_fine <= FINE_STEP_MAX)
		##1 clk_en && $stable(st_q.image)
		|=> !fine_range_err)
	else $error("fine range flag without overflow");

	min_fine_read_a: assert property (
		@(posedge mclk) disable iff (!rst_n_q)
		clk_en && reg_rd && reg_addr == TX_MIN_LASER_FREQ_FINE
		|=> reg_rdata == $past(min_fine[WORD_W-1:DATA_W]))
	else $error("min fine high byte wrong");

	thr_low_byte_a: assert property (
		@(posedge mclk) disable iff (!rst_n_q)
		clk_en && reg_rd && reg_addr == RX_POWER_LOW_ALARM_PERMITTED_MAX + 16'h0001
		|=> reg_rdata == $past(thr_la[DATA_W-1:0]))
	else $error("threshold low byte wrong");

	thr_flags_a: assert property (
		@(posedge mclk) disable iff (!rst_n_q)
		thr_supported[2:1] == {(|thr_la), (|thr_lw)})
	else $error("support flags disagree with words");

	// A stalled clock enable must not let a load or a read slip through
	freeze_hold_a: assert property (
		@(posedge mclk) disable iff (!rst_n_q)
		!clk_en |=> $stable(st_q))
	else $error("state moved with clock enable low");

	rdata_hold_a: assert property (
		@(posedge mclk) disable iff (!rst_n_q)
		!(clk_en && reg_rd) |=> $stable(reg_rdata))
	else $error("read data moved without a read");

	checksum_read_c: cover property (
		@(posedge mclk) disable iff (!rst_n_q)
		clk_en && reg_rd && reg_addr == PAGE_TWO_CHECKSUM);

	load_then_read_c: cover property (
		@(posedge mclk) disable iff (!rst_n_q)
		clk_en && nv_load ##1 clk_en && reg_rd && rd_dec[IDX_W]);

	range_err_c: cover property (
		@(posedge mclk) disable iff (!rst_n_q)
		fine_range_err);

	unsupported_c: cover property (
		@(posedge mclk) disable iff (!rst_n_q)
		!thr_supported[2]);

	frozen_read_c: cover property (
		@(posedge mclk) disable iff (!rst_n_q)
		!clk_en && reg_rd);

endmodule : nvid_regs

`default_nettype wire

// *** bench/nvid_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module nvid_host
	import nvid_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic [DATA_W-1:0] reg_rdata,
	output logic      [ADDR_W-1:0] reg_addr,
	output logic      [DATA_W-1:0] reg_wdata,
	output logic                   reg_wr,
	output logic                   reg_rd
);
	initial
	begin
		reg_addr = '0;
		reg_wdata = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Idle bus shows inverted values, so a stale address never passes as a match
	task rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge mclk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd   <= 1'b0;
		reg_addr <= ~a;
		#1 d = reg_rdata;
	endtask : rd

	task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge mclk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr    <= 1'b0;
		reg_addr  <= ~a;
		reg_wdata <= ~d;
	endtask : wr

	// Host skips the range check of a limit that reads 0000h
	function automatic logic in_range(input logic [WORD_W-1:0] lim, input logic [WORD_W-1:0] v);
		return (lim == THR_UNSUPPORTED) || ($signed(v) <= $signed(lim));
	endfunction : in_range
endmodule : nvid_host
`default_nettype wire

// *** bench/nonvolatile_id_register_segment_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_total++; \
	$display("unexpected %s expected %h seen %h", nm, e, g); end end
module nonvolatile_id_register_segment_bench
	import nvid_pkg::*;
;
	logic              mclk, resetn, clk_en, nv_load, reg_wr, reg_rd, fine_range_err;
	logic [IDX_W-1:0]  nv_index;
	logic [DATA_W-1:0] nv_data, head_sum, reg_wdata, reg_rdata, rd_d;
	logic [ADDR_W-1:0] reg_addr;
	logic [NUM_THR-1:0] thr_supported;
	int                err_total = 0;
	int                n_checks = 0;
	// Thresholds: -5.00 dBm, unsupported, -2.00 dBm; fine min sits on 19999
	logic [WORD_W-1:0] wv [7] = '{16'hfe0c, 16'h0000, 16'hff38, 16'h00c1, 16'h4e1f, 16'h00c5, 16'h0064};
	logic [ADDR_W-1:0] wa [7] = '{RX_POWER_HIGH_WARNING_PERMITTED_MAX,
		RX_POWER_LOW_WARNING_PERMITTED_MAX, RX_POWER_LOW_ALARM_PERMITTED_MAX,
		TX_MIN_LASER_FREQ_COARSE, TX_MIN_LASER_FREQ_FINE, TX_MAX_LASER_FREQ_COARSE,
		TX_MAX_LASER_FREQ_FINE};

	always #20 mclk = ~mclk;

	nvid_regs u_dut (.mclk(mclk), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.nv_load(nv_load), .nv_index(nv_index), .nv_data(nv_data),
		.page_two_head_sum(head_sum), .thr_supported(thr_supported),
		.fine_range_err(fine_range_err));
	nvid_host u_host (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

	////////////////////////////////////////////////////////////////////////////
	task ld(input logic [IDX_W-1:0] i, input logic [DATA_W-1:0] d);
		@(posedge mclk);
		nv_load  <= 1'b1;
		nv_index <= i;
		nv_data  <= d;
		@(posedge mclk);
		nv_load  <= 1'b0;
	endtask : ld

	task t_image;
		logic [DATA_W-1:0] sum;
		logic [WORD_W-1:0] rw;
		sum = head_sum;
		for (int w = 0; w < 7; w++)
		begin
			ld(IDX_W'(2 * w), wv[w][15:8]);
			ld(IDX_W'(2 * w + 1), wv[w][7:0]);
		end
		for (int w = 0; w < 7; w++)
		begin
			u_host.rd(wa[w], rd_d);
			`CHK("word high", wv[w][15:8], rd_d)
			rw[WORD_W-1:DATA_W] = rd_d;
			u_host.rd(wa[w] + 16'h1, rd_d);
			`CHK("word low", wv[w][7:0], rd_d)
			rw[DATA_W-1:0] = rd_d;
			if (w < 3) sum = sum + wv[w][15:8] + wv[w][7:0];
			if (w == 0) `CHK("range check", 1'b0, u_host.in_range(rw, 16'hff38))
			if (w == 1) `CHK("skip check", 1'b1, u_host.in_range(rw, 16'h7fff))
		end
		u_host.rd(PAGE_TWO_CHECKSUM, rd_d);
		`CHK("checksum", sum, rd_d)
		`CHK("supported", 3'h5, thr_supported)
		`CHK("fine err", 1'b0, fine_range_err)
		$display("t_image done");
	endtask : t_image

	task t_reserved;
		for (int i = 0; i < 7; i++) u_host.wr(PAGE_TWO_RESERVED_TAIL_LO + 16'(i), 8'hff);
		u_host.wr(PAGE_THREE_CHECKSUM_SLOT, 8'hff);
		u_host.wr(TX_MIN_LASER_FREQ_COARSE, 8'hff);
		for (int i = 0; i < 7; i++)
		begin
			u_host.rd(PAGE_TWO_RESERVED_TAIL_LO + 16'(i), rd_d);
			`CHK("reserved", 8'h00, rd_d)
		end
		u_host.rd(PAGE_THREE_CHECKSUM_SLOT, rd_d);
		`CHK("slot", 8'h00, rd_d)
		u_host.rd(TX_MIN_LASER_FREQ_COARSE, rd_d);
		`CHK("read only", wv[3][15:8], rd_d)
		u_host.rd(16'h9000, rd_d);
		`CHK("unmapped", 8'h00, rd_d)
		$display("t_reserved done");
	endtask : t_reserved

	task t_fine_err;
		ld(4'h9, 8'h20);
		repeat (2) @(posedge mclk);
		#1 `CHK("min fine over", 1'b1, fine_range_err)
		ld(4'h9, 8'h1f);
		repeat (2) @(posedge mclk);
		#1 `CHK("min fine back", 1'b0, fine_range_err)
		ld(4'hc, 8'h4e);
		ld(4'hd, 8'h20);
		repeat (2) @(posedge mclk);
		#1 `CHK("max fine over", 1'b1, fine_range_err)
		$display("t_fine_err done");
	endtask : t_fine_err

	task t_freeze;
		u_host.rd(TX_MAX_LASER_FREQ_COARSE + 16'h1, rd_d);
		`CHK("before freeze", wv[5][7:0], rd_d)
		@(posedge mclk);
		clk_en <= 1'b0;
		u_host.rd(TX_MAX_LASER_FREQ_COARSE, rd_d);
		`CHK("frozen read", wv[5][7:0], rd_d)
		ld(4'hb, 8'h33);
		@(posedge mclk);
		clk_en <= 1'b1;
		u_host.rd(TX_MAX_LASER_FREQ_COARSE + 16'h1, rd_d);
		`CHK("frozen load", wv[5][7:0], rd_d)
		$display("t_freeze done");
	endtask : t_freeze

	task t_reset;
		@(posedge mclk);
		resetn <= 1'b0;
		repeat (2) @(posedge mclk);
		#1 `CHK("flag in reset", 1'b0, fine_range_err)
		`CHK("support in reset", 3'h0, thr_supported)
		repeat (2) @(posedge mclk);
		resetn <= 1'b1;
		repeat (6) @(posedge mclk);
		u_host.rd(TX_MIN_LASER_FREQ_FINE, rd_d);
		`CHK("image after reset", 8'h00, rd_d)
		$display("t_reset done");
	endtask : t_reset

	task print_verdict;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	initial
	begin
		#200000;
		err_total++;
		print_verdict();
	end

	initial
	begin
		mclk = 1'b0;
		resetn = 1'b0;
		clk_en = 1'b1;
		nv_load = 1'b0;
		nv_index = '0;
		nv_data = '0;
		head_sum = 8'h5a;
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		repeat (6) @(posedge mclk);
		t_image();
		t_reserved();
		t_freeze();
		t_fine_err();
		t_reset();
		print_verdict();
	end
endmodule : nonvolatile_id_register_segment_bench
`default_nettype wire
